// ### verilog/eee_pkg.sv
// shared constants and types for the eee transmit lpi timing block
package eee_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] LPI_DELAY_OFS = 12'h130;
  localparam logic [ADDR_W-1:0] WAKE_WAIT_OFS = 12'h134;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h150;
  localparam logic [ADDR_W-1:0] STATE_OFS = 12'h154;
  localparam logic [ADDR_W-1:0] INTERRUPT_STATUS_REGISTER_OFS = 12'h158;
  localparam logic [ADDR_W-1:0] INT_CLR_OFS = 12'h15C;
  localparam logic [ADDR_W-1:0] INT_EN_OFS = 12'h160;
  localparam int CTRL_EN_BIT = 0;
  localparam int INT_W = 2;
  localparam int INT_ENTRY_BIT = 0;
  localparam int INT_WAKE_BIT = 1;
  localparam int WAKE_GIG_LSB = 16;
  localparam int WAKE_FAST_LSB = 0;
  localparam logic [31:0] LPI_DELAY_RST = 32'h0000_0000;
  localparam logic [15:0] WAKE_GIG_RST = 16'h0021;
  localparam logic [15:0] WAKE_FAST_RST = 16'h001E;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [7:0] LPI_TXD_CODE = 8'h01;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_NS = 1000;
  localparam int HALF_TICK_RAW = (TICK_TIME_NS / 2) / CLK_PERIOD_NS;
  localparam int HALF_TICK_CYCLES = HALF_TICK_RAW < 1 ? 1 : HALF_TICK_RAW;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_LPI = 4'h4,
    ST_WAKE = 4'h8
  } eee_state_type;

  function automatic logic eee_eligible(input logic en,
    input logic [1:0] speed, input logic fullDuplex, input logic bothEee);
    eee_eligible = en && fullDuplex && bothEee &&
      (speed == SPEED_100 || speed == SPEED_1000);
  endfunction : eee_eligible
endpackage : eee_pkg

// ### verilog/eee_reg_if.sv
// register access path between the bus slave and the register file
`timescale 1ns/1ps
interface eee_reg_if;
  import eee_pkg::*;
  logic wrEn;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wrEn, output addr, output wdata, input rdata);
  modport regs (input wrEn, input addr, input wdata, output rdata);
endinterface : eee_reg_if

// ### verilog/eee_us_tick.sv
// free-running prescaler giving half-microsecond and microsecond ticks
`timescale 1ns/1ps
module eee_us_tick
  import eee_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_TICK_CYCLES
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // ticks
  output logic halfTick,
  output logic usTick
);
  localparam int CW = HALF_CYCLES > 1 ? $clog2(HALF_CYCLES) : 1;
  logic [CW-1:0] cnt_q;
  logic phase_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      phase_q <= 1'b0;
      halfTick <= 1'b0;
      usTick <= 1'b0;
    end
    else if (cnt_q == CW'(HALF_CYCLES - 1))
    begin
      cnt_q <= '0;
      phase_q <= ~phase_q;
      halfTick <= 1'b1;
      usTick <= phase_q;
    end
    else
    begin
      cnt_q <= cnt_q + CW'(1);
      halfTick <= 1'b0;
      usTick <= 1'b0;
    end
  end
endmodule : eee_us_tick

// ### verilog/eee_ahb_slave.sv
// ahb-lite slave: writes in zero wait states, reads with one wait state
`timescale 1ns/1ps
module eee_ahb_slave
  import eee_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register path
  eee_reg_if.slave regs
);
  logic pendWr_q;
  logic pendRd_q;
  logic rdDone_q;
  logic mapped_q;
  logic [ADDR_W-1:0] addr_q;
  logic accept;
  logic mapped;

  assign accept = hsel && htrans[1];
  // odd sizes, misaligned or out-of-window addresses are dropped quietly
  assign mapped = hsize == HSIZE_WORD && haddr[1:0] == 2'h0 &&
    haddr[31:ADDR_W] == '0;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendWr_q <= 1'b0;
      pendRd_q <= 1'b0;
      rdDone_q <= 1'b0;
      mapped_q <= 1'b0;
      addr_q <= '0;
    end
    else if (hready)
    begin
      pendWr_q <= accept && hwrite;
      pendRd_q <= accept && !hwrite;
      rdDone_q <= 1'b0;
      mapped_q <= mapped;
      addr_q <= haddr[ADDR_W-1:0];
    end
    else if (pendRd_q)
      rdDone_q <= 1'b1;
  end

  // read data is captured in the wait state so that a write just before
  // is already visible
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (pendRd_q && !rdDone_q)
      hrdata <= mapped_q ? regs.rdata : 32'h0000_0000;
  end

  assign hreadyout = !(pendRd_q && !rdDone_q);
  assign hresp = 1'b0;
  assign regs.wrEn = pendWr_q && mapped_q;
  assign regs.addr = addr_q;
  assign regs.wdata = hwdata;
endmodule : eee_ahb_slave

// ### verilog/eee_tx_lpi_timing.sv
// transmit low-power-idle entry and wake timing with its registers
// Behaviour
// - 32-bit entry delay in us, resets zero
// - feature disabled: no lpi action at all
// - delay elapsed: start lpi, set entry flag
// - entry and fast wake waits timed by 1 us tick, gigabit wake by 0.5 us tick, maybe longer
// - zero delay enters lpi with no wait
// - fifo data during wait restarts timer
// - wake wait holds transmit, before gap
// - fast wake: lower half, 1 us, 30
// - lpi needs enable, speed, duplex, negotiation
`timescale 1ns/1ps
module eee_tx_lpi_timing
  import eee_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // ahb-lite register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // mac transmit path and link status
  input wire logic txFifoEmpty,
  input wire logic [1:0] linkSpeed,
  input wire logic linkFullDuplex,
  input wire logic linkBothEee,
  output logic txLpiActive,
  output logic txHold,
  // lpi symbols toward the phy
  output logic lpiTxEn,
  output logic lpiTxEr,
  output logic [7:0] lpiTxd,
  // interrupt
  output logic irq
);
  eee_reg_if regBus ();

  logic halfTick;
  logic usTick;
  logic energyEfficientEnable_q;
  logic [31:0] lpiEntryDelayCount_q;
  logic [15:0] wakeWaitGigabitCount_q;
  logic [15:0] wakeWaitFastCount_q;
  logic [INT_W-1:0] intSts_q;
  logic [INT_W-1:0] intEn_q;
  logic irq_q;
  eee_state_type state_q;
  logic [31:0] entryCnt_q;
  logic [15:0] wakeCnt_q;
  logic wakeGig_q;
  logic lpiTxEr_q;
  logic [7:0] lpiTxd_q;
  logic eligible;
  logic entryFire;
  logic wakeTick;
  logic [15:0] wakeTarget;
  logic wakeDone;
  logic [INT_W-1:0] intClr;
  logic [INT_W-1:0] intSet;
  logic [INT_W-1:0] intEnNext;
  logic stIdle;
  logic stWait;
  logic stLpi;
  logic stWake;

  eee_ahb_slave u_slave (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .regs(regBus.slave)
  );

  // shared prescaler keeps entry and wake waits on one time base
  eee_us_tick u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .halfTick(halfTick),
    .usTick(usTick)
  );

  function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
    wr_hit = regBus.wrEn && regBus.addr == ofs;
  endfunction : wr_hit

  // software registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      energyEfficientEnable_q <= 1'b0;
      lpiEntryDelayCount_q <= LPI_DELAY_RST;
      wakeWaitGigabitCount_q <= WAKE_GIG_RST;
      wakeWaitFastCount_q <= WAKE_FAST_RST;
      intEn_q <= '0;
    end
    else
    begin
      if (wr_hit(CTRL_OFS))
        energyEfficientEnable_q <= regBus.wdata[CTRL_EN_BIT];
      // counts are taken as written; the enable is not checked here
      if (wr_hit(LPI_DELAY_OFS))
        lpiEntryDelayCount_q <= regBus.wdata;
      if (wr_hit(WAKE_WAIT_OFS))
      begin
        wakeWaitGigabitCount_q <= regBus.wdata[WAKE_GIG_LSB +: 16];
        wakeWaitFastCount_q <= regBus.wdata[WAKE_FAST_LSB +: 16];
      end
      if (wr_hit(INT_EN_OFS))
        intEn_q <= regBus.wdata[INT_W-1:0];
    end
  end

  always_comb
  begin
    regBus.rdata = 32'h0000_0000;
    unique case (regBus.addr)
      LPI_DELAY_OFS: regBus.rdata = lpiEntryDelayCount_q;
      WAKE_WAIT_OFS: regBus.rdata = {wakeWaitGigabitCount_q,
        wakeWaitFastCount_q};
      CTRL_OFS: regBus.rdata[CTRL_EN_BIT] = energyEfficientEnable_q;
      STATE_OFS: regBus.rdata[3:0] = state_q;
      INTERRUPT_STATUS_REGISTER_OFS: regBus.rdata[INT_W-1:0] = intSts_q;
      INT_EN_OFS: regBus.rdata[INT_W-1:0] = intEn_q;
      default: regBus.rdata = 32'h0000_0000;
    endcase
  end

  assign stIdle = state_q == ST_IDLE;
  assign stWait = state_q == ST_WAIT;
  assign stLpi = state_q == ST_LPI;
  assign stWake = state_q == ST_WAKE;

  assign eligible = eee_eligible(energyEfficientEnable_q, linkSpeed,
    linkFullDuplex, linkBothEee);

  // expiry needs delay+1 ticks, so the wait is never short of the count
  assign entryFire = txFifoEmpty && eligible &&
    ((stIdle && lpiEntryDelayCount_q == 32'h0000_0000) ||
     (stWait && usTick && entryCnt_q == lpiEntryDelayCount_q));

  assign wakeTick = wakeGig_q ? halfTick : usTick;
  assign wakeTarget = wakeGig_q ? wakeWaitGigabitCount_q :
    wakeWaitFastCount_q;
  assign wakeDone = stWake && wakeTick && wakeCnt_q == wakeTarget;

  // entry and wake timing
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      entryCnt_q <= 32'h0000_0000;
      wakeCnt_q <= 16'h0000;
      wakeGig_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          entryCnt_q <= 32'h0000_0000;
          if (entryFire)
            state_q <= ST_LPI;
          else if (txFifoEmpty && eligible)
            state_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (!txFifoEmpty || !eligible)
            state_q <= ST_IDLE;
          else if (entryFire)
            state_q <= ST_LPI;
          else if (usTick)
            entryCnt_q <= entryCnt_q + 32'h0000_0001;
        end
        ST_LPI:
        begin
          if (!txFifoEmpty || !eligible)
          begin
            state_q <= ST_WAKE;
            wakeCnt_q <= 16'h0000;
            wakeGig_q <= linkSpeed == SPEED_1000;
          end
        end
        ST_WAKE:
        begin
          if (wakeDone)
            state_q <= ST_IDLE;
          else if (wakeTick)
            wakeCnt_q <= wakeCnt_q + 16'h0001;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // lpi symbols: tx enable low, error high, code on the data lanes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lpiTxEr_q <= 1'b0;
      lpiTxd_q <= 8'h00;
    end
    else
    begin
      lpiTxEr_q <= stLpi && txFifoEmpty && eligible;
      lpiTxd_q <= (stLpi && txFifoEmpty && eligible) ?
        LPI_TXD_CODE : 8'h00;
    end
  end

  assign lpiTxEn = 1'b0;
  assign lpiTxEr = lpiTxEr_q;
  assign lpiTxd = lpiTxd_q;
  assign txLpiActive = stLpi;
  // the mac starts its normal gap only after this drops
  assign txHold = stWake || stLpi;

  // interrupts: a set in the same cycle as a clear wins
  assign intClr = wr_hit(INT_CLR_OFS) ? regBus.wdata[INT_W-1:0] : '0;
  assign intSet = {wakeDone, entryFire};
  // the level follows an enable write in the same cycle, not one later
  assign intEnNext = wr_hit(INT_EN_OFS) ? regBus.wdata[INT_W-1:0] : intEn_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intSts_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      intSts_q <= (intSts_q & ~intClr) | intSet;
      irq_q <= |(((intSts_q & ~intClr) | intSet) & intEnNext);
    end
  end

  assign irq = irq_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence seqWaitToLpi;
    stWait ##1 stLpi;
  endsequence
  sequence seqWakeToIdle;
    stWake ##1 stIdle;
  endsequence
  sequence seqLeaveIdle;
    stIdle ##1 !stIdle;
  endsequence

  disabled_no_lpi_a: assert property (
    !energyEfficientEnable_q |=> !stWait && !(stLpi && !$past(stLpi)))
    else $error("lpi activity while feature disabled");

  zero_delay_entry_a: assert property (
    stIdle && txFifoEmpty && eligible &&
    lpiEntryDelayCount_q == 32'h0000_0000 |=> stLpi)
    else $error("zero delay did not enter lpi at once");

  entry_wait_full_a: assert property (
    seqWaitToLpi |-> $past(usTick, 1) &&
    $past(entryCnt_q, 1) == lpiEntryDelayCount_q)
    else $error("lpi entered before the wait elapsed");

  entry_flag_set_a: assert property (
    !stLpi ##1 stLpi |-> intSts_q[INT_ENTRY_BIT])
    else $error("entry flag not set on lpi entry");

  restart_on_data_a: assert property (
    stWait && !txFifoEmpty |=> stIdle ##1 entryCnt_q == 32'h0000_0000)
    else $error("wait timer not restarted on fifo data");

  entry_conditions_a: assert property (
    seqLeaveIdle |-> $past(eligible, 1) && $past(txFifoEmpty, 1))
    else $error("lpi requested without eligibility");

  lpi_symbols_a: assert property (
    stLpi && txFifoEmpty && eligible |=> lpiTxEr &&
    lpiTxd == LPI_TXD_CODE && !lpiTxEn)
    else $error("lpi encoding missing");

  lpi_stops_a: assert property (
    stLpi && !txFifoEmpty |=> stWake && !lpiTxEr && txHold)
    else $error("lpi not stopped on fifo data");

  gig_wake_time_a: assert property (
    seqWakeToIdle ##0 $past(wakeGig_q, 1) |-> $past(halfTick, 1) &&
    $past(wakeCnt_q, 1) == wakeWaitGigabitCount_q)
    else $error("gigabit wake wait wrong");

  fast_wake_time_a: assert property (
    seqWakeToIdle ##0 !$past(wakeGig_q, 1) |-> $past(usTick, 1) &&
    $past(wakeCnt_q, 1) == wakeWaitFastCount_q)
    else $error("fast wake wait wrong");

  tick_period_a: assert property (
    usTick |=> (!usTick) [*8] ##1 !usTick ##1 usTick)
    else $error("microsecond tick period wrong");

  hold_in_wake_a: assert property (
    stLpi ##1 stWake |-> txHold [*2])
    else $error("transmit not held after lpi exit");

  entry_set_wins_a: assert property (
    entryFire |=> intSts_q[INT_ENTRY_BIT])
    else $error("entry event lost to a clear");

  wake_flag_set_a: assert property (
    wakeDone |=> intSts_q[INT_WAKE_BIT])
    else $error("wake done flag not set");

  irq_level_a: assert property (
    irq == |(intSts_q & intEn_q))
    else $error("interrupt level does not follow status");

  lpi_code_idle_a: assert property (
    !lpiTxEr |-> lpiTxd == 8'h00)
    else $error("lpi code outside lpi");
endmodule : eee_tx_lpi_timing

// ### dv/eee_phy_model.sv
// phy-side model that decodes lpi symbols on the transmit path
`timescale 1ns/1ps
module eee_phy_model
  import eee_pkg::*;
(
  // transmit symbols
  input wire logic lpiTxEn,
  input wire logic lpiTxEr,
  input wire logic [7:0] lpiTxd,
  // decoded state
  output logic lpiSeen
);
  // lpi is error asserted without enable, carrying the lpi code
  assign lpiSeen = !lpiTxEn && lpiTxEr && lpiTxd == LPI_TXD_CODE;
endmodule : eee_phy_model

// ### dv/eee_tx_lpi_timing_tb.sv
// self-checking bench for the eee transmit lpi timing block
`timescale 1ns/1ps
module eee_tx_lpi_timing_tb;
  import eee_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n, hsel, hwrite, hreadyout, hresp, rdStrobe;
  logic txFifoEmpty, linkFullDuplex, linkBothEee;
  logic txLpiActive, txHold, lpiTxEn, lpiTxEr, irq, lpiSeen;
  logic [31:0] haddr, hwdata, hrdata, rdData, seed;
  logic [1:0] htrans, linkSpeed;
  logic [2:0] hsize;
  logic [7:0] lpiTxd;
  logic [3:0] badLink [4];
  logic [31:0] expQ [$];
  int badCount, checkCount, n;

  always #50 sys_clk = ~sys_clk;

  eee_tx_lpi_timing u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .txFifoEmpty(txFifoEmpty),
    .linkSpeed(linkSpeed), .linkFullDuplex(linkFullDuplex),
    .linkBothEee(linkBothEee), .txLpiActive(txLpiActive), .txHold(txHold),
    .lpiTxEn(lpiTxEn), .lpiTxEr(lpiTxEr), .lpiTxd(lpiTxd), .irq(irq));

  eee_phy_model u_phy (.lpiTxEn(lpiTxEn), .lpiTxEr(lpiTxEr),
    .lpiTxd(lpiTxd), .lpiSeen(lpiSeen));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic pick(input int k);
    pick = k == 0 ? txLpiActive : k == 1 ? txHold : k == 2 ? irq : lpiSeen;
  endfunction : pick

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkVal

  task automatic conclude;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic timeout;
    badCount++;
    conclude();
  endtask : timeout

  // hready is read mid-cycle so the value matches what the edge samples
  task automatic waitRdy;
    int k;
    k = 0;
    forever
    begin
      @(negedge sys_clk);
      if (hreadyout === 1'b1)
        break;
      if (++k > 20)
        timeout();
    end
    chkVal({31'h0, hresp}, 32'h0);
    rdData = hrdata;
    @(posedge sys_clk);
  endtask : waitRdy

  task automatic busGo(input logic [ADDR_W-1:0] a, input logic w,
    input logic [31:0] d);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
  endtask : busGo

  task automatic busWr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    busGo(a, 1'b1, d);
  endtask : busWr

  task automatic busRd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    expQ.push_back(e);
    busGo(a, 1'b0, 32'h0);
    rdStrobe <= 1'b1;
    @(posedge sys_clk);
    rdStrobe <= 1'b0;
  endtask : busRd

  // read results are compared as they appear, in the order noted
  always @(posedge sys_clk)
    if (rdStrobe === 1'b1)
      chkVal(rdData, expQ.pop_front());

  task automatic chkSig(input int k, input logic e);
    @(negedge sys_clk);
    chkVal({31'h0, pick(k)}, {31'h0, e});
    @(posedge sys_clk);
  endtask : chkSig

  task automatic waitSig(input int k, input logic e, output int c);
    c = 0;
    forever
    begin
      @(negedge sys_clk);
      if (pick(k) === e)
        break;
      if (++c > 600)
        timeout();
    end
    @(posedge sys_clk);
  endtask : waitSig

  task automatic inRange(input int c, input int lo, input int hi);
    chkVal({31'h0, c >= lo && c <= hi}, 32'h1);
  endtask : inRange

  task automatic setLink(input logic [3:0] v);
    {linkSpeed, linkFullDuplex, linkBothEee} <= v;
    @(posedge sys_clk);
  endtask : setLink

  initial
  begin
    badLink = '{4'b0011, 4'b1111, 4'b0101, 4'b1010};
    seed = 32'h0E379B19;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    txFifoEmpty = 1'b0;
    linkSpeed = SPEED_100;
    linkFullDuplex = 1'b1;
    linkBothEee = 1'b1;
    rdStrobe = 1'b0;
    badCount = 0;
    checkCount = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    busRd(LPI_DELAY_OFS, LPI_DELAY_RST);
    busRd(WAKE_WAIT_OFS, {WAKE_GIG_RST, WAKE_FAST_RST});
    busRd(INTERRUPT_STATUS_REGISTER_OFS, 32'h0);
    busRd(12'h200, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      seed = lfsr(seed);
      busWr(i == 0 ? LPI_DELAY_OFS : WAKE_WAIT_OFS, seed);
      busRd(i == 0 ? LPI_DELAY_OFS : WAKE_WAIT_OFS, seed);
    end
    busWr(LPI_DELAY_OFS, 32'h0);
    busWr(WAKE_WAIT_OFS, {WAKE_GIG_RST, WAKE_FAST_RST});
    $display("test registers done");
    txFifoEmpty <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chkSig(1, 1'b0);
    chkSig(3, 1'b0);
    busRd(STATE_OFS, 32'h1);
    $display("test disabled done");
    setLink(badLink[0]);
    busWr(CTRL_OFS, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      setLink(badLink[i]);
      repeat (20) @(posedge sys_clk);
      chkSig(0, 1'b0);
    end
    txFifoEmpty <= 1'b0;
    setLink(4'b0111);
    $display("test eligibility done");
    busWr(INT_EN_OFS, 32'h3);
    txFifoEmpty <= 1'b1;
    waitSig(0, 1'b1, n);
    inRange(n, 1, 1);
    chkSig(2, 1'b1);
    chkSig(3, 1'b1);
    busRd(INTERRUPT_STATUS_REGISTER_OFS, 32'h1);
    txFifoEmpty <= 1'b0;
    waitSig(0, 1'b0, n);
    inRange(n, 1, 1);
    chkSig(3, 1'b0);
    waitSig(1, 1'b0, n);
    inRange(n, 295, 312);
    busRd(INTERRUPT_STATUS_REGISTER_OFS, 32'h3);
    busWr(INT_CLR_OFS, 32'h3);
    busRd(INTERRUPT_STATUS_REGISTER_OFS, 32'h0);
    chkSig(2, 1'b0);
    $display("test zero delay done");
    busWr(CTRL_OFS, 32'h0);
    busWr(LPI_DELAY_OFS, 32'h32);
    busWr(INT_EN_OFS, 32'h0);
    setLink(4'b1011);
    busWr(CTRL_OFS, 32'h1);
    txFifoEmpty <= 1'b1;
    repeat (25) @(posedge sys_clk);
    chkSig(0, 1'b0);
    txFifoEmpty <= 1'b0;
    @(posedge sys_clk);
    txFifoEmpty <= 1'b1;
    waitSig(0, 1'b1, n);
    inRange(n, 502, 512);
    chkSig(2, 1'b0);
    busRd(INTERRUPT_STATUS_REGISTER_OFS, 32'h1);
    busWr(INT_EN_OFS, 32'h1);
    chkSig(2, 1'b1);
    txFifoEmpty <= 1'b0;
    waitSig(1, 1'b0, n);
    inRange(n, 164, 178);
    busWr(INT_CLR_OFS, 32'h3);
    chkSig(2, 1'b0);
    busRd(INTERRUPT_STATUS_REGISTER_OFS, 32'h0);
    $display("test gigabit restart done");
    repeat (4) @(posedge sys_clk);
    conclude();
  end
endmodule : eee_tx_lpi_timing_tb
